// *** sbst_pkg.sv ***
// Purpose: Constants and types for the memory boundary-scan test port
// Assumes: Test clock is sampled by ref_clk through two flip-flops
// Notes: Behaviour
// Behaviour
// R01 - Inputs sampled at test clock rise, outputs updated after test clock fall.
// R02 - Mode select steps controller each rise; undriven mode select reads as one.
// R03 - Serial in shifts into selected register at rise; undriven reads as one.
// R04 - Selected serial path follows controller state and held instruction.
// R05 - Serial out enabled only in shift states, changes at test clock fall.
// R06 - Five rises with mode select high reach test-logic-reset.
// R07 - Controller reset at power-up; idle while test clock stands still.
// R08 - Outside controller selects one register at a time by mode select sequence.
// R09 - Each test register captures at rise, presents outgoing bit at next fall.
// R10 - Instruction is three bits, takes effect from update-IR onward.
// R11 - Instruction register shifts only while it is the connected path.
// R12 - Identification instruction loaded at power-up and in test-logic-reset.
// R13 - Bypass is one flip-flop, one test clock of delay.
// R14 - Boundary cells capture input and two-way pins, chained to serial out.
// R15 - Boundary cells with no pin always capture one.
// R16 - Boundary instruction captures ring in capture-DR, shifts in shift-DR.
// R17 - Boundary path only for output-disable sample, sample/preload, external test.
// R18 - Codes: 000 extest, 001 id, 010 hiz sample, 100 sample, 111 bypass.
// R19 - Capture-IR loads low two instruction bits with 01.
// R20 - Identification register is 32 bits, constant capture, shifts LSB first.
// R21 - Output-disable sample forces outputs high impedance except echo clocks.
// R22 - Controller follows standard sixteen-state sequence.
`default_nettype none
package sbst_pkg;
  localparam int SBST_IR_W = 3;
  localparam int SBST_ID_W = 32;
  localparam logic [2:0] SBST_OP_EXTEST = 3'h0;
  localparam logic [2:0] SBST_OP_IDCODE = 3'h1;
  localparam logic [2:0] SBST_OP_HIZ_SAMPLE = 3'h2;
  localparam logic [2:0] SBST_OP_SAMPLE = 3'h4;
  localparam logic [2:0] SBST_OP_BYPASS = 3'h7;
  localparam logic [1:0] SBST_IR_CAPTURE = 2'h1;
  // Arbitrary neutral identification value
  localparam logic [31:0] SBST_ID_DEFAULT = 32'h0000_0001;
  localparam int SBST_RESET_ONES = 5;

  typedef enum {
    SBST_TLR, SBST_RTI, SBST_SEL_DR, SBST_CAP_DR, SBST_SH_DR, SBST_EX1_DR,
    SBST_PAU_DR, SBST_EX2_DR, SBST_UPD_DR, SBST_SEL_IR, SBST_CAP_IR,
    SBST_SH_IR, SBST_EX1_IR, SBST_PAU_IR, SBST_EX2_IR, SBST_UPD_IR
  } sbst_state_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbst_pins_s;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sbst_out_s;
endpackage
`default_nettype wire

// *** sbst_shift_reg.sv ***
// Purpose: Generic capture/shift serial register
// Assumes: Strobes are one ref_clk cycle long
// Notes: Shifts toward bit zero, serial out is bit zero
`default_nettype none
module sbst_shift_reg #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic capture,
  input wire logic shift,
  input wire logic [W-1:0] cap_data,
  input wire logic ser_in,
  output logic [W-1:0] q
);
  logic [W-1:0] next_q;

  // Single-bit case must not elaborate the part-select
  if (W == 1) begin : g_one
    assign next_q = ser_in;
  end else begin : g_many
    assign next_q = {ser_in, q[W-1:1]};
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (capture) begin
      q <= cap_data;
    end else if (shift) begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// *** sbst_tap.sv ***
// Purpose: Boundary-scan test access port of the memory device
// Assumes: ref_clk far faster than test clock; pins have pull-ups outside
// Notes: Test clock edges are found by sampling, not used as a clock
`default_nettype none
module sbst_tap #(
  parameter int BSR_W = 16,
  parameter logic [BSR_W-1:0] BSR_PIN_MASK = '1,
  parameter int N_OUT = 8,
  parameter int N_ECHO = 2,
  parameter logic [31:0] ID_VALUE = sbst_pkg::SBST_ID_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire sbst_pkg::sbst_pins_s pins,
  input wire logic [BSR_W-1:0] ring_in,
  output sbst_pkg::sbst_out_s tdo_out,
  output logic [BSR_W-1:0] bsr_update,
  output logic extest_drive,
  output logic [N_OUT-1:0] mem_out_en_mask,
  output logic [N_ECHO-1:0] echo_clock_out_en
);
  import sbst_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers and test clock edges
  // ------------------------------------------------------------
  sbst_pins_s meta;
  sbst_pins_s sync;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;
  logic [BSR_W-1:0] ring_meta;
  logic [BSR_W-1:0] ring_sync;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '1;
      sync <= '1;
    end else begin
      meta <= pins; // [R02] [R03]
      sync <= meta;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_prev <= 1'b1;
    end else begin
      tck_prev <= sync.tck;
    end
  end

  // Ring levels come from the memory pins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ring_meta <= '0;
      ring_sync <= '0;
    end else begin
      ring_meta <= ring_in; // [R14]
      ring_sync <= ring_meta;
    end
  end

  // No edges while test clock stands still, so nothing moves [R07] [R01]
  assign tck_rise = sync.tck && !tck_prev;
  assign tck_fall = !sync.tck && tck_prev;

  // ------------------------------------------------------------
  // Controller state machine
  // ------------------------------------------------------------
  sbst_state_e state;
  sbst_state_e next_state;
  logic tms;
  assign tms = sync.tms;

  always_comb begin
    next_state = state;
    case (state) // [R22] [R06]
      SBST_TLR: next_state = tms ? SBST_TLR : SBST_RTI;
      SBST_RTI: next_state = tms ? SBST_SEL_DR : SBST_RTI;
      SBST_SEL_DR: next_state = tms ? SBST_SEL_IR : SBST_CAP_DR;
      SBST_CAP_DR: next_state = tms ? SBST_EX1_DR : SBST_SH_DR;
      SBST_SH_DR: next_state = tms ? SBST_EX1_DR : SBST_SH_DR;
      SBST_EX1_DR: next_state = tms ? SBST_UPD_DR : SBST_PAU_DR;
      SBST_PAU_DR: next_state = tms ? SBST_EX2_DR : SBST_PAU_DR;
      SBST_EX2_DR: next_state = tms ? SBST_UPD_DR : SBST_SH_DR;
      SBST_UPD_DR: next_state = tms ? SBST_SEL_DR : SBST_RTI;
      SBST_SEL_IR: next_state = tms ? SBST_TLR : SBST_CAP_IR;
      SBST_CAP_IR: next_state = tms ? SBST_EX1_IR : SBST_SH_IR;
      SBST_SH_IR: next_state = tms ? SBST_EX1_IR : SBST_SH_IR;
      SBST_EX1_IR: next_state = tms ? SBST_UPD_IR : SBST_PAU_IR;
      SBST_PAU_IR: next_state = tms ? SBST_EX2_IR : SBST_PAU_IR;
      SBST_EX2_IR: next_state = tms ? SBST_UPD_IR : SBST_SH_IR;
      SBST_UPD_IR: next_state = tms ? SBST_SEL_DR : SBST_RTI;
      default: next_state = SBST_TLR;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SBST_TLR; // [R07]
    end else if (tck_rise) begin
      state <= next_state; // [R02]
    end
  end

  // ------------------------------------------------------------
  // Instruction register
  // ------------------------------------------------------------
  logic [SBST_IR_W-1:0] ir_shift;
  logic [SBST_IR_W-1:0] ir_held;
  logic ir_cap;
  logic ir_sh;
  assign ir_cap = tck_rise && state == SBST_CAP_IR;
  // Shifting only while instruction path is connected [R11] [R03]
  assign ir_sh = tck_rise && state == SBST_SH_IR;

  sbst_shift_reg #(
    .W(SBST_IR_W)
  ) u_ir (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .capture(ir_cap),
    .shift(ir_sh),
    .cap_data({ir_held[2], SBST_IR_CAPTURE}), // [R19]
    .ser_in(sync.tdi),
    .q(ir_shift)
  );

  // Held instruction active from update-IR onward [R10]
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_held <= SBST_OP_IDCODE; // [R12]
    end else if (tck_rise && next_state == SBST_TLR) begin
      ir_held <= SBST_OP_IDCODE; // [R12]
    end else if (tck_fall && state == SBST_UPD_IR) begin
      ir_held <= ir_shift;
    end
  end

  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  logic sel_bsr;
  logic sel_id;
  logic hiz_active;
  // Reserved and private codes fall through to bypass [R18]
  assign sel_bsr = ir_held == SBST_OP_EXTEST || ir_held == SBST_OP_HIZ_SAMPLE ||
                   ir_held == SBST_OP_SAMPLE; // [R17]
  assign sel_id = ir_held == SBST_OP_IDCODE; // [R18]
  assign hiz_active = ir_held == SBST_OP_HIZ_SAMPLE;

  // ------------------------------------------------------------
  // Data registers
  // ------------------------------------------------------------
  logic dr_cap;
  logic dr_sh;
  logic [BSR_W-1:0] bsr_q;
  logic [SBST_ID_W-1:0] id_q;
  logic [0:0] byp_q;
  assign dr_cap = tck_rise && state == SBST_CAP_DR;
  assign dr_sh = tck_rise && state == SBST_SH_DR;

  // Unpinned cells capture one [R15] [R14]
  sbst_shift_reg #(
    .W(BSR_W)
  ) u_bsr (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .capture(dr_cap && sel_bsr), // [R16]
    .shift(dr_sh && sel_bsr),
    .cap_data((ring_sync & BSR_PIN_MASK) | ~BSR_PIN_MASK),
    .ser_in(sync.tdi),
    .q(bsr_q)
  );

  // LSB first from constant value [R20]
  sbst_shift_reg #(
    .W(SBST_ID_W)
  ) u_id (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .capture(dr_cap && sel_id),
    .shift(dr_sh && sel_id),
    .cap_data(ID_VALUE),
    .ser_in(sync.tdi),
    .q(id_q)
  );

  // Single flip-flop path [R13]
  sbst_shift_reg #(
    .W(1)
  ) u_byp (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .capture(dr_cap && !sel_bsr && !sel_id),
    .shift(dr_sh && !sel_bsr && !sel_id),
    .cap_data(1'b0),
    .ser_in(sync.tdi),
    .q(byp_q)
  );

  // ------------------------------------------------------------
  // Serial out, updated at test clock fall
  // ------------------------------------------------------------
  logic next_tdo;
  logic shifting;
  assign shifting = state == SBST_SH_DR || state == SBST_SH_IR;

  always_comb begin
    next_tdo = byp_q[0];
    if (state == SBST_SH_IR) begin // [R04]
      next_tdo = ir_shift[0];
    end else if (sel_bsr) begin
      next_tdo = bsr_q[0];
    end else if (sel_id) begin
      next_tdo = id_q[0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo_out <= '0;
    end else if (tck_fall) begin
      tdo_out.tdo <= next_tdo; // [R05] [R09] [R01]
      tdo_out.tdo_oe <= shifting; // [R05]
    end
  end

  // ------------------------------------------------------------
  // Boundary update and output control
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bsr_update <= '0;
    end else if (tck_fall && state == SBST_UPD_DR && sel_bsr) begin
      bsr_update <= bsr_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      extest_drive <= 1'b0;
      mem_out_en_mask <= '1;
      echo_clock_out_en <= '1;
    end else begin
      extest_drive <= ir_held == SBST_OP_EXTEST;
      mem_out_en_mask <= {N_OUT{!hiz_active}}; // [R21]
      echo_clock_out_en <= '1; // [R21]
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  localparam logic [2:0] ONES_DONE = 3'(SBST_RESET_ONES);
  logic [2:0] ones_cnt;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ones_cnt <= '0;
    end else if (tck_rise) begin
      ones_cnt <= !tms ? 3'h0 : (ones_cnt == ONES_DONE ? ones_cnt : ones_cnt + 3'h1);
    end
  end

  property p_five_ones;
    @(posedge ref_clk) disable iff (!rst_b) ones_cnt == ONES_DONE |-> state == SBST_TLR;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("No reset after five ones"); // [R06]

  property p_tlr_idcode;
    @(posedge ref_clk) disable iff (!rst_b) state == SBST_TLR |-> ir_held == SBST_OP_IDCODE;
  endproperty
  a_tlr_idcode: assert property (p_tlr_idcode) else $error("Not idcode in reset"); // [R12]

  property p_tdo_fall;
    @(posedge ref_clk) disable iff (!rst_b) !tck_fall |=> $stable(tdo_out);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("Serial out moved off fall"); // [R05]

  property p_state_rise;
    @(posedge ref_clk) disable iff (!rst_b) !tck_rise |=> $stable(state);
  endproperty
  a_state_rise: assert property (p_state_rise) else $error("State moved off rise"); // [R02]

  property p_ir_cap;
    @(posedge ref_clk) disable iff (!rst_b) ir_cap |=> ir_shift[1:0] == SBST_IR_CAPTURE;
  endproperty
  a_ir_cap: assert property (p_ir_cap) else $error("Capture-IR pattern wrong"); // [R19]

  property p_ir_hold;
    @(posedge ref_clk) disable iff (!rst_b) state != SBST_SH_IR && !ir_cap |=> $stable(ir_shift);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("Instruction shifted off path"); // [R11]

  property p_byp_delay;
    @(posedge ref_clk) disable iff (!rst_b)
      dr_sh && !sel_bsr && !sel_id |=> byp_q[0] == $past(sync.tdi);
  endproperty
  a_byp_delay: assert property (p_byp_delay) else $error("Bypass bit wrong"); // [R13]

  property p_hiz;
    @(posedge ref_clk) disable iff (!rst_b)
      hiz_active |=> mem_out_en_mask == '0 && echo_clock_out_en == '1;
  endproperty
  a_hiz: assert property (p_hiz) else $error("Outputs not disabled"); // [R21]

  sequence s_shift_fall;
    tck_fall && shifting;
  endsequence
  property p_oe;
    @(posedge ref_clk) disable iff (!rst_b) s_shift_fall |=> tdo_out.tdo_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("Serial out not enabled"); // [R05]

  property p_oe_off;
    @(posedge ref_clk) disable iff (!rst_b) tck_fall && !shifting |=> !tdo_out.tdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("Serial out enabled off shift"); // [R05]

  property p_bsr_cap;
    @(posedge ref_clk) disable iff (!rst_b)
      dr_cap && sel_bsr |=> (bsr_q & BSR_PIN_MASK) == ($past(ring_sync) & BSR_PIN_MASK);
  endproperty
  a_bsr_cap: assert property (p_bsr_cap) else $error("Ring capture wrong"); // [R14]

  property p_bsr_fill;
    @(posedge ref_clk) disable iff (!rst_b) dr_cap && sel_bsr |=> &(bsr_q | BSR_PIN_MASK);
  endproperty
  a_bsr_fill: assert property (p_bsr_fill) else $error("Unpinned cell not one"); // [R15]

  property p_id_cap;
    @(posedge ref_clk) disable iff (!rst_b) dr_cap && sel_id |=> id_q == ID_VALUE;
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("Identification capture wrong"); // [R20]

  property p_ir_update;
    @(posedge ref_clk) disable iff (!rst_b)
      tck_fall && state == SBST_UPD_IR |=> ir_held == $past(ir_shift);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("Instruction not updated"); // [R10]

  property p_extest;
    @(posedge ref_clk) disable iff (!rst_b) ir_held == SBST_OP_EXTEST |=> extest_drive;
  endproperty
  a_extest: assert property (p_extest) else $error("External test drive off"); // [R18]

  sequence s_upd_dr_fall;
    tck_fall && state == SBST_UPD_DR && sel_bsr;
  endsequence
  property p_bsr_update;
    @(posedge ref_clk) disable iff (!rst_b) s_upd_dr_fall |=> bsr_update == $past(bsr_q);
  endproperty
  a_bsr_update: assert property (p_bsr_update) else $error("Boundary update wrong"); // [R16]
endmodule
`default_nettype wire

// *** sbst_ctrl_model.sv ***
// Purpose: Behavioural scan controller driving the test pins
// Assumes: Test clock period 125 ns, held low between frames
// Notes: Mode select and serial in change only while test clock is low
`default_nettype none
module sbst_ctrl_model (
  output sbst_pkg::sbst_pins_s pins
);
  timeunit 1ns;
  timeprecision 100ps;
  import sbst_pkg::*;
  real half_ns = 62.5;
  initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
  // ----------------------------------------
  // One test clock pulse
  // ----------------------------------------
  task automatic step(input logic tms_v, input logic tdi_v);
    pins.tms = tms_v;
    pins.tdi = tdi_v;
    #(half_ns) pins.tck = 1'b1;
    #(half_ns) pins.tck = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sram_boundary_scan_tap_bench.sv ***
// Purpose: Self-checking bench for the boundary-scan test port
// Assumes: Serial out settles well before the next test clock rise
// Notes: Expected serial bits are queued and checked at each rise with out enabled
`default_nettype none
module sram_boundary_scan_tap_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sbst_pkg::*;
  localparam logic [15:0] PIN_MASK = 16'hfff0;
  // Arbitrary identification value
  localparam logic [31:0] ID_VAL = 32'h5a3c_0f01;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] ring_in = 16'h0000;
  sbst_pins_s pins;
  sbst_out_s tdo_out;
  logic [15:0] bsr_update;
  logic extest_drive;
  logic [7:0] mem_out_en_mask;
  logic [1:0] echo_clock_out_en;
  logic exp_q[$];
  int failures = 0;
  int check_count = 0;
  integer seed = 32'h2cee_2107;
  logic [2:0] held = 3'h1;
  logic [31:0] pat;
  logic e;

  always #5 ref_clk = ~ref_clk;

  sbst_ctrl_model sbst_ctrl_model_inst (.pins(pins));

  sbst_tap #(.BSR_W(16), .BSR_PIN_MASK(PIN_MASK), .N_OUT(8), .N_ECHO(2),
    .ID_VALUE(ID_VAL)) sbst_tap_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .pins(pins), .ring_in(ring_in),
    .tdo_out(tdo_out), .bsr_update(bsr_update), .extest_drive(extest_drive),
    .mem_out_en_mask(mem_out_en_mask), .echo_clock_out_en(echo_clock_out_en));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge pins.tck) begin
    if (tdo_out.tdo_oe === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 1'bx;
      check({31'd0, tdo_out.tdo}, {31'd0, e});
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic end_test(input string name);
    check(exp_q.size(), 32'd0);
    $display("Test %s done", name);
  endtask

  // ----------------------------------------
  // Controller walks
  // ----------------------------------------
  task automatic walk(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++) begin
      sbst_ctrl_model_inst.step(seq[i], 1'b1);
    end
  endtask

  task automatic shift_ir(input logic [2:0] code);
    walk(8'h03, 4);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(i == 0 ? 1'b1 : (i == 1 ? 1'b0 : held[2]));
      sbst_ctrl_model_inst.step(i == 2, code[i]);
    end
    walk(8'h01, 2);
    held = code;
  endtask

  task automatic shift_dr(input int n, input logic [31:0] din, input logic [31:0] exp);
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(exp[i]);
      sbst_ctrl_model_inst.step(i == n - 1, din[i]);
    end
    walk(8'h01, 2);
  endtask

  task automatic pulse_reset();
    @(posedge ref_clk);
    #1 rst_b = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1 held = 3'h1;
  endtask

  initial begin
    #500_000;
    failures++;
    close_out();
  end

  initial begin
    pulse_reset();
    check({30'd0, tdo_out}, 32'd0);
    pat = $random(seed);
    walk(8'h00, 1);
    shift_dr(32, pat, ID_VAL);
    end_test("id");
    for (int c = 0; c < 8; c++) begin
      shift_ir(3'(c));
      pat = $random(seed);
      @(posedge ref_clk);
      #1 ring_in = pat[31:16];
      if (c == 1) begin
        shift_dr(32, pat, ID_VAL);
      end else if (c == 0 || c == 2 || c == 4) begin
        shift_dr(16, pat, {16'd0, pat[31:16] | ~PIN_MASK});
        check({16'd0, bsr_update}, {16'd0, pat[15:0]});
      end else begin
        shift_dr(8, pat, {24'd0, pat[6:0], 1'b0});
      end
      check({31'd0, extest_drive}, {31'd0, c == 0});
      check({24'd0, mem_out_en_mask}, (c == 2) ? 32'd0 : 32'h0000_00ff);
      check({30'd0, echo_clock_out_en}, 32'h0000_0003);
      end_test("code");
    end
    walk(8'h03, 4);
    exp_q.push_back(1'b1);
    walk(8'h1f, 5);
    held = 3'h1;
    walk(8'h00, 1);
    shift_dr(32, ~pat, ID_VAL);
    end_test("five_ones");
    shift_ir(3'h7);
    pulse_reset();
    walk(8'h00, 1);
    shift_dr(32, pat, ID_VAL);
    end_test("mid_reset");
    close_out();
  end
endmodule
`default_nettype wire
